// ### src/cwcs_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Three-stage pin synchroniser; change accepted when stages two and three agree
module cwcs_pin_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic pin_out
);
  import cwcs_pkg::*;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic out_reg;
  logic out_next;

  // Shift and qualify
  always_comb begin
    sync_next = {sync_reg[1:0], pin_in};
    out_next = (sync_reg[2] == sync_reg[1]) ? sync_reg[2] : out_reg;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_reg <= 3'h0;
      out_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      out_reg <= out_next;
    end
  end
  assign pin_out = out_reg;
endmodule : cwcs_pin_sync
`default_nettype wire

// ### src/cwcs_pkg.sv
// Summary of operation
// - 14-bit word, zero means programmed, 11:9 zero
// - Bits 13:12 bandgap trim, hidden on export
// - Bit 8 low protects data; off erases
// - Bit 7 low protects program; off erases
// - Bit 6 high enables brown-out, not delay
// - Bit 5 high selects external reset pin
// - Reset pin in internal/RC stops oscillator
// - Bit 4 low enables power-up delay
// - Bit 3 high enables watchdog
// - 111/110 RC, with/without quarter clock
// - 101/100 internal, with/without quarter clock
// - 011 external clock, output pin I/O
// - 010/001/000 high/standard/low-power crystal
// - Quarter clock is oscillator divided by four
// - Internal oscillator 4 MHz, starts in 8
// - Configuration space only in programming mode
// - Crystal modes wait 1024 input cycles
package cwcs_pkg;
  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int CWCS_WORD_W = 14;
  localparam logic [15:0] CWCS_CFG_ADDR = 16'h2007;
  localparam logic [15:0] CWCS_CFG_SPACE_LO = 16'h2000;
  localparam logic [15:0] CWCS_CFG_SPACE_HI = 16'h3FFF;
  localparam logic [15:0] CWCS_TRIM_ADDR = 16'h03FF;
  localparam int CWCS_BG_HI = 13;
  localparam int CWCS_BG_LO = 12;
  localparam int CWCS_DCP_BIT = 8;
  localparam int CWCS_PCP_BIT = 7;
  localparam int CWCS_BOD_BIT = 6;
  localparam int CWCS_RST_BIT = 5;
  localparam int CWCS_PUD_BIT = 4;
  localparam int CWCS_WDT_BIT = 3;
  localparam int CWCS_CS_HI = 2;
  localparam logic [13:0] CWCS_IMPL_MASK = 14'h31FF;
  localparam logic [13:0] CWCS_EXPORT_MASK = 14'h01FF;
  localparam logic [13:0] CWCS_ERASED = 14'h3FFF;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CWCS_OST_CYCLES = 1024;
  localparam int CWCS_INTERNAL_OSCILLATOR_START = 8;
  localparam logic [1:0] CWCS_DIV_LAST = 2'h3;

  typedef enum logic [2:0] {
    CWCS_LP = 3'h0, CWCS_XT = 3'h1, CWCS_HS = 3'h2, CWCS_EC = 3'h3,
    CWCS_INT_IO = 3'h4, CWCS_INT_CLK = 3'h5, CWCS_RC_IO = 3'h6, CWCS_RC_CLK = 3'h7
  } cwcs_clksel_t;

  typedef struct packed {
    logic [1:0] bandgap_trim;
    logic data_read_protect;
    logic program_read_protect;
    logic brownout_detect_enable;
    logic reset_pin_select;
    logic powerup_delay_enable;
    logic watchdog_enable;
    cwcs_clksel_t clock_source_select;
  } cwcs_settings_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [13:0] wdata;
    logic write;
    logic read;
  } cwcs_prog_req_t;
endpackage : cwcs_pkg

// ### src/cwcs_top.sv
`timescale 1ns/100ps
`default_nettype none
module cwcs_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic prog_mode,
  input wire cwcs_pkg::cwcs_prog_req_t prog_req,
  output logic [13:0] prog_rdata,
  output logic prog_ack,
  input wire logic [13:0] nvm_word,
  input wire logic clock_pin_in,
  input wire logic ext_reset_in,
  input wire logic osc_clk_in,
  input wire logic int_osc_clk,
  input wire logic rc_osc_clk,
  input wire logic wake_event,
  output cwcs_pkg::cwcs_settings_t settings,
  output logic data_erase_req,
  output logic program_erase_req,
  output logic int_osc_enable,
  output logic crystal_drive_enable,
  output logic clock_in_is_io,
  output logic clock_out_is_io,
  output logic clock_pin_out,
  output logic clock_pin_out_oe_n,
  output logic external_reset_pin,
  output logic sys_clk_sel,
  output logic startup_hold,
  output logic osc_ready
);
  import cwcs_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic osc_in_s;
  logic int_s;
  logic rc_s;
  logic xin_s;
  logic rst_pin_s;
  cwcs_pin_sync u_sync_osc (.mclk(mclk), .sys_rst(sys_rst), .pin_in(osc_clk_in),
    .pin_out(osc_in_s));
  cwcs_pin_sync u_sync_int (.mclk(mclk), .sys_rst(sys_rst), .pin_in(int_osc_clk),
    .pin_out(int_s));
  cwcs_pin_sync u_sync_rc (.mclk(mclk), .sys_rst(sys_rst), .pin_in(rc_osc_clk),
    .pin_out(rc_s));
  cwcs_pin_sync u_sync_xin (.mclk(mclk), .sys_rst(sys_rst), .pin_in(clock_pin_in),
    .pin_out(xin_s));
  cwcs_pin_sync u_sync_rst (.mclk(mclk), .sys_rst(sys_rst), .pin_in(ext_reset_in),
    .pin_out(rst_pin_s));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_crystal(input cwcs_clksel_t cs);
    is_crystal = (cs == CWCS_LP) || (cs == CWCS_XT) || (cs == CWCS_HS);
  endfunction : is_crystal

  function automatic logic in_cfg_space(input logic [15:0] a);
    in_cfg_space = (a >= CWCS_CFG_SPACE_LO) && (a <= CWCS_CFG_SPACE_HI);
  endfunction : in_cfg_space

  // ----------------------------------------
  // Stored word and latched settings
  // ----------------------------------------
  logic [13:0] word_reg;
  logic [13:0] word_next;
  logic loaded_reg;
  logic loaded_next;
  cwcs_settings_t set_reg;
  cwcs_settings_t set_next;
  logic derase_reg;
  logic derase_next;
  logic perase_reg;
  logic perase_next;
  logic [13:0] rdata_reg;
  logic [13:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic cfg_hit;

  assign cfg_hit = prog_mode && (prog_req.addr == CWCS_CFG_ADDR);

  // Programming access and capture of the word after reset release
  always_comb begin
    word_next = word_reg;
    loaded_next = 1'b1;
    set_next = set_reg;
    derase_next = 1'b0;
    perase_next = 1'b0;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    // Unimplemented bits forced to zero
    if (!loaded_reg) begin
      word_next = nvm_word & CWCS_IMPL_MASK;
    end else if (prog_mode && prog_req.write && in_cfg_space(prog_req.addr)) begin
      ack_next = 1'b1;
      if (cfg_hit) begin
        // Trim bits are factory held, never overwritten by tools
        word_next = (prog_req.wdata & CWCS_EXPORT_MASK) | (word_reg & ~CWCS_EXPORT_MASK);
        // Protection going off wipes the protected memory
        derase_next = !word_reg[CWCS_DCP_BIT] && prog_req.wdata[CWCS_DCP_BIT];
        perase_next = !word_reg[CWCS_PCP_BIT] && prog_req.wdata[CWCS_PCP_BIT];
      end
    end else if (prog_mode && prog_req.read && in_cfg_space(prog_req.addr)) begin
      ack_next = 1'b1;
      // Export hides trim bits
      rdata_next = cfg_hit ? (word_reg & CWCS_EXPORT_MASK) : 14'h0000;
    end
    // Decoded settings only follow the word right at load
    if (!loaded_reg) begin
      set_next.bandgap_trim = word_next[CWCS_BG_HI:CWCS_BG_LO];
      set_next.data_read_protect = !word_next[CWCS_DCP_BIT];
      set_next.program_read_protect = !word_next[CWCS_PCP_BIT];
      set_next.brownout_detect_enable = word_next[CWCS_BOD_BIT];
      set_next.reset_pin_select = word_next[CWCS_RST_BIT];
      set_next.powerup_delay_enable = !word_next[CWCS_PUD_BIT];
      set_next.watchdog_enable = word_next[CWCS_WDT_BIT];
      set_next.clock_source_select = cwcs_clksel_t'(word_next[CWCS_CS_HI:0]);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_reg <= CWCS_ERASED & CWCS_IMPL_MASK;
      loaded_reg <= 1'b0;
      set_reg <= '0;
      derase_reg <= 1'b0;
      perase_reg <= 1'b0;
      rdata_reg <= 14'h0000;
      ack_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      loaded_reg <= loaded_next;
      set_reg <= set_next;
      derase_reg <= derase_next;
      perase_reg <= perase_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  // ----------------------------------------
  // Clock source selection and pins
  // ----------------------------------------
  cwcs_clksel_t cs;
  logic quarter_on;
  logic int_mode;
  logic rc_mode;
  logic src_clk;
  assign cs = set_reg.clock_source_select;
  assign int_mode = (cs == CWCS_INT_IO) || (cs == CWCS_INT_CLK);
  assign rc_mode = (cs == CWCS_RC_IO) || (cs == CWCS_RC_CLK);
  assign quarter_on = (cs == CWCS_RC_CLK) || (cs == CWCS_INT_CLK);

  // Source mux; crystal modes take whatever toggles the input pin
  always_comb begin
    case (cs)
      CWCS_RC_CLK, CWCS_RC_IO: src_clk = rc_s;
      CWCS_INT_CLK, CWCS_INT_IO: src_clk = int_s;
      CWCS_EC: src_clk = xin_s;
      default: src_clk = osc_in_s;
    endcase
  end

  // Pin roles and oscillator enables
  always_comb begin
    // Internal/RC oscillator stops when reset pin is selected
    int_osc_enable = (int_mode || rc_mode) && !set_reg.reset_pin_select && loaded_reg;
    crystal_drive_enable = is_crystal(cs) && loaded_reg;
    clock_in_is_io = int_mode;
    clock_out_is_io = (cs == CWCS_RC_IO) || (cs == CWCS_INT_IO) || (cs == CWCS_EC);
    // Internal reset held inactive high when pin is plain I/O
    external_reset_pin = set_reg.reset_pin_select ? rst_pin_s : 1'b1;
  end

  // ----------------------------------------
  // Quarter-rate divider and start-up timing
  // ----------------------------------------
  logic src_d_reg;
  logic src_d_next;
  logic src_rise;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic qclk_reg;
  logic qclk_next;
  logic [10:0] ost_reg;
  logic [10:0] ost_next;
  logic hold_reg;
  logic hold_next;
  logic crystal_wait;
  logic [10:0] ost_target;
  assign src_rise = src_clk && !src_d_reg;
  assign crystal_wait = is_crystal(cs);
  assign ost_target = crystal_wait ? 11'(CWCS_OST_CYCLES) : 11'(CWCS_INTERNAL_OSCILLATOR_START);

  // Divide source by four; count start-up cycles on power-up or wake
  always_comb begin
    src_d_next = src_clk;
    div_next = div_reg;
    qclk_next = qclk_reg;
    ost_next = ost_reg;
    hold_next = hold_reg;
    if (src_rise) begin
      div_next = div_reg + 2'h1;
      if (div_reg[0]) begin
        qclk_next = !qclk_reg;
      end
    end
    if (wake_event) begin
      ost_next = 11'h000;
      hold_next = 1'b1;
    end else if (hold_reg && loaded_reg && src_rise) begin
      // 1024 input cycles for crystals; 8 for the internal source
      if (ost_reg == ost_target - 11'h001) begin
        hold_next = 1'b0;
      end else begin
        ost_next = ost_reg + 11'h001;
      end
    end
    // Modes without a start-up wait release at once
    if (loaded_reg && !crystal_wait && !int_mode) begin
      hold_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      src_d_reg <= 1'b0;
      div_reg <= 2'h0;
      qclk_reg <= 1'b0;
      ost_reg <= 11'h000;
      hold_reg <= 1'b1;
    end else begin
      src_d_reg <= src_d_next;
      div_reg <= div_next;
      qclk_reg <= qclk_next;
      ost_reg <= ost_next;
      hold_reg <= hold_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign settings = set_reg;
  assign data_erase_req = derase_reg;
  assign program_erase_req = perase_reg;
  assign prog_rdata = rdata_reg;
  assign prog_ack = ack_reg;
  assign clock_pin_out = quarter_on ? qclk_reg : 1'b0;
  assign clock_pin_out_oe_n = !quarter_on; // Low while driving
  assign sys_clk_sel = src_clk;
  assign startup_hold = hold_reg;
  assign osc_ready = !hold_reg && loaded_reg;
endmodule : cwcs_top
`default_nettype wire

// ### verif/cwcs_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module cwcs_osc_model (
  input wire logic int_en,
  output logic osc_clk_in,
  output logic clock_pin_in,
  output logic int_osc_clk,
  output logic rc_osc_clk
);
  // ----------------------------------------
  // Far-side clock sources
  // ----------------------------------------
  // Clock driven straight into the input pin, 10 MHz
  initial begin
    osc_clk_in = 1'b0;
    forever #50 osc_clk_in = ~osc_clk_in;
  end
  assign clock_pin_in = osc_clk_in;
  // Internal source, 4 MHz; parks low when disabled so a stopped clock shows
  initial begin
    int_osc_clk = 1'b0;
    forever #125 int_osc_clk = (int_en === 1'b1) ? ~int_osc_clk : 1'b0;
  end
  // RC network, odd period on purpose
  initial begin
    rc_osc_clk = 1'b0;
    forever #170 rc_osc_clk = ~rc_osc_clk;
  end
endmodule : cwcs_osc_model
`default_nettype wire

// ### verif/cwcs_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module cwcs_top_asserts
  import cwcs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic prog_mode,
  input wire cwcs_pkg::cwcs_prog_req_t prog_req,
  input wire logic prog_ack,
  input wire logic [13:0] nvm_word,
  input wire cwcs_pkg::cwcs_settings_t settings,
  input wire logic data_erase_req,
  input wire logic program_erase_req,
  input wire logic int_osc_enable,
  input wire logic clock_pin_out,
  input wire logic clock_pin_out_oe_n,
  input wire logic external_reset_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Steps of a request and of a load
  // ----------------------------------------
  sequence cfg_req;
    prog_mode && (prog_req.read || prog_req.write) && prog_req.addr[15:13] == 3'h1;
  endsequence
  sequence load_edge;
    $past(sys_rst) && !sys_rst;
  endsequence
  // Word fields decoded on the load edge
  AST_DECODE_PROT: assert property (load_edge |=>
    settings.data_read_protect != $past(nvm_word[8])
    && settings.program_read_protect != $past(nvm_word[7])
    && settings.powerup_delay_enable != $past(nvm_word[4]))
    else $error("protect or delay bits decoded wrongly");
  AST_DECODE_EN: assert property (load_edge |=>
    settings.bandgap_trim == $past(nvm_word[13:12])
    && settings.brownout_detect_enable == $past(nvm_word[6])
    && settings.reset_pin_select == $past(nvm_word[5])
    && settings.watchdog_enable == $past(nvm_word[3])
    && settings.clock_source_select == $past(nvm_word[2:0]))
    else $error("enable or clock bits decoded wrongly");
  // Settings frozen; second edge skipped since the load lands there
  AST_HOLD: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(settings))
    else $error("settings changed outside reset");
  AST_ACK_TAKEN: assert property (cfg_req |=> prog_ack)
    else $error("config access not acknowledged");
  AST_ACK_REFUSED: assert property (!prog_mode |=> !prog_ack)
    else $error("access acknowledged outside programming");
  AST_RST_PIN: assert property (!settings.reset_pin_select |-> external_reset_pin)
    else $error("reset pin not tied inactive");
  AST_INT_OFF: assert property (settings.reset_pin_select && settings.clock_source_select[2]
    |-> !int_osc_enable)
    else $error("internal oscillator left on");
  AST_PIN_IDLE: assert property (clock_pin_out_oe_n |-> !clock_pin_out)
    else $error("quarter clock active while not driven");
  AST_PIN_DRIVE: assert property (!clock_pin_out_oe_n
    |-> settings.clock_source_select[2] && settings.clock_source_select[0])
    else $error("clock pin driven in wrong mode");
  AST_DATA_ERASE: assert property (data_erase_req |-> $past(prog_mode && prog_req.write
    && prog_req.addr == 16'h2007 && prog_req.wdata[8]))
    else $error("data erase without unprotect write");
  AST_PROG_ERASE: assert property (program_erase_req |-> $past(prog_mode && prog_req.write
    && prog_req.addr == 16'h2007 && prog_req.wdata[7]))
    else $error("program erase without unprotect write");
endmodule : cwcs_top_asserts
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cwcs_pkg::*;
  logic mclk, sys_rst, prog_mode, ext_reset_in, wake_event, prog_ack, data_erase_req;
  logic program_erase_req, int_osc_enable, crystal_drive_enable, clock_in_is_io;
  logic clock_out_is_io, clock_pin_out, clock_pin_out_oe_n, external_reset_pin, sys_clk_sel;
  logic startup_hold, osc_ready, osc_clk_in, clock_pin_in, int_osc_clk, rc_osc_clk;
  logic [13:0] nvm_word, prog_rdata, w;
  logic [2:0] k, got;
  cwcs_prog_req_t prog_req;
  cwcs_settings_t settings;
  int err_count = 0, check_count = 0, cyc = 0, n;
  cwcs_top cwcs_top_i (.mclk, .sys_rst, .prog_mode, .prog_req, .prog_rdata, .prog_ack,
    .nvm_word, .clock_pin_in, .ext_reset_in, .osc_clk_in, .int_osc_clk, .rc_osc_clk,
    .wake_event, .settings, .data_erase_req, .program_erase_req, .int_osc_enable,
    .crystal_drive_enable, .clock_in_is_io, .clock_out_is_io, .clock_pin_out,
    .clock_pin_out_oe_n, .external_reset_pin, .sys_clk_sel, .startup_hold, .osc_ready);
  cwcs_osc_model cwcs_osc_model_i (.int_en(int_osc_enable), .osc_clk_in, .clock_pin_in,
    .int_osc_clk, .rc_osc_clk);
  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Longest path is one crystal start-up, near 5200 cycles
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  function automatic cwcs_settings_t exp_of(input logic [13:0] v);
    return '{v[13:12], !v[8], !v[7], v[6], v[5], !v[4], v[3], cwcs_clksel_t'(v[2:0])};
  endfunction : exp_of
  task automatic boot(input logic [13:0] v);
    sys_rst <= 1'b1;
    nvm_word <= v;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : boot
  // One-cycle request taken at the next edge; ack and erase pulses read one edge later
  task automatic access(input logic [15:0] a, input logic [13:0] d, input logic wr);
    prog_req <= '{a, d, wr, !wr};
    @(posedge mclk);
    prog_req <= '0;
    @(posedge mclk);
    got = {prog_ack, data_erase_req, program_erase_req};
  endtask : access
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    prog_mode = 1'b0;
    prog_req = '0;
    nvm_word = 14'h3FFF;
    ext_reset_in = 1'b0;
    wake_event = 1'b0;
    // Every clock mode, other fields varied with it
    for (int cs = 0; cs < 8; cs++) begin
      k = cs[2:0];
      w = {2'h2, 3'h0, k[1], k[2], k[1], k[0], k[2], k[0], k};
      boot(w);
      check("settings", settings, exp_of(w));
      check("oe_n", clock_pin_out_oe_n, !(k[2] && k[0]));
      check("in_io", clock_in_is_io, k[2:1] == 2'h2);
      check("out_io", clock_out_is_io, k == 3'h6 || k == 3'h4 || k == 3'h3);
      check("xtal", crystal_drive_enable, k < 3'h3);
      check("int_osc", int_osc_enable, k[2] && !k[0]);
      check("rst_pin", external_reset_pin, !k[0]);
    end
    // Programming access, protection on, internal clock with quarter output
    boot(14'h2005);
    access(16'h2007, 14'h0000, 1'b0);
    check("ack_off", got[2], 1'b0);
    prog_mode <= 1'b1;
    access(16'h2007, 14'h0000, 1'b0);
    check("ack", got, 3'h4);
    check("rdata", prog_rdata, 14'h0005);
    access(16'h1FFF, 14'h0000, 1'b0);
    check("ack_out", got[2], 1'b0);
    // Last program word holds the trim literal; plain memory, never config space
    access(16'h03FF, 14'h0000, 1'b0);
    check("ack_trim", got[2], 1'b0);
    access(16'h2006, 14'h0000, 1'b0);
    check("other_ack", got[2], 1'b1);
    check("other", prog_rdata, 14'h0000);
    access(16'h2007, 14'h3F85, 1'b1);
    check("erase", got, 3'h7);
    check("frozen", settings, exp_of(14'h2005));
    access(16'h2007, 14'h0000, 1'b0);
    check("readback", prog_rdata, 14'h0185);
    prog_mode <= 1'b0;
    repeat (20) @(posedge int_osc_clk);
    check("int_start", startup_hold, 1'b0);
    n = 0;
    fork
      repeat (40) @(posedge int_osc_clk);
      forever @(posedge clock_pin_out) n++;
    join_any
    disable fork;
    check("quarter", n >= 9 && n <= 11, 1'b1);
    // Crystal start-up, then wake
    boot(14'h2011);
    repeat (1000) @(posedge osc_clk_in);
    check("ost_wait", startup_hold, 1'b1);
    repeat (40) @(posedge osc_clk_in);
    check("ost_done", startup_hold, 1'b0);
    wake_event <= 1'b1;
    @(posedge mclk);
    wake_event <= 1'b0;
    repeat (10) @(posedge mclk);
    check("wake", startup_hold, 1'b1);
    boot(14'h2013);
    repeat (10) @(posedge mclk);
    check("ec_start", startup_hold, 1'b0);
    stop_test();
  end
endmodule : tb_top
bind cwcs_top cwcs_top_asserts cwcs_top_asserts_i (.mclk, .sys_rst, .prog_mode, .prog_req,
  .prog_ack, .nvm_word, .settings, .data_erase_req, .program_erase_req, .int_osc_enable,
  .clock_pin_out, .clock_pin_out_oe_n, .external_reset_pin);
`default_nettype wire
